// *** src/dram_termination_control.sv ***
// Termination controller of the die: configuration registers, command capture and the
// data termination sequencer.
// Assumes the command pins and command clock come from outside the system clock domain,
// and the register port and power-state inputs come from logic on the system clock.
//
// Chosen here: the register offsets and strobed register access.
`include "term_consts.svh"

module dram_termination_control (
    input  wire logic                CLK_SYS,
    input  wire logic                RSTN,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR_STB,
    input  wire logic                RD_STB,
    output logic      [7:0]          RDATA,
    input  wire logic                CMD_CLOCK_TRUE,
    input  wire logic                CMD_WRITE1,
    input  wire logic                CMD_MASK_WRITE1,
    input  wire logic                CMD_CAS2,
    input  wire logic                PWR_DOWN,
    input  wire logic                SELF_REFRESH,
    input  wire logic                WRITE_LEVELING,
    output logic                     DQ_TERM_EN,
    output logic                     DQS_TERM_EN,
    output term_pkg::rzq_div_t       DATA_TERM_DIV,
    output term_pkg::rzq_div_t       CA_TERM_DIV
);
    import term_pkg::*;

    localparam int TON      = `TERM_ON_MIN_CYC;
    localparam int TOFF     = `TERM_OFF_MIN_CYC;
    localparam int TON_P1   = TON + 1;
    localparam int TOFF_P1  = TOFF + 1;
    localparam int CA_UPD   = `CA_UPDATE_CYC;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [7:0]  cfg_q;
    logic [7:0]  ctrl_q;
    logic        cfg_wr;
    logic        ca_write;

    assign cfg_wr   = WR_STB && (ADDR == `OFS_TERM_CFG);
    assign ca_write = cfg_wr && (WDATA[`CA_FIELD_MSB:`CA_FIELD_LSB]
                                 != cfg_q[`CA_FIELD_MSB:`CA_FIELD_LSB]);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q  <= `TERM_CFG_RESET; // R15
            ctrl_q <= `TERM_CTRL_RESET;
        end else if (WR_STB) begin
            if (ADDR == `OFS_TERM_CFG) begin
                cfg_q <= {1'b0, WDATA[6:0]};
            end else if (ADDR == `OFS_TERM_CTRL) begin
                ctrl_q <= {3'h0, WDATA[4:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Command pin synchronisers
    // ------------------------------------------------------------------
    // A change is accepted only when the second and third stages agree, which
    // keeps a metastable settle from showing up as a false command clock edge.
    logic [3:0]  pins;
    logic [3:0]  s1_q;
    logic [3:0]  s2_q;
    logic [3:0]  s3_q;
    logic [3:0]  flt_q;

    assign pins = {CMD_CLOCK_TRUE, CMD_WRITE1, CMD_MASK_WRITE1, CMD_CAS2};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge CLK_SYS or negedge RSTN) begin
            if (!RSTN) begin
                s1_q[i]  <= 1'b0;
                s2_q[i]  <= 1'b0;
                s3_q[i]  <= 1'b0;
                flt_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= pins[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    flt_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic ck_edge;
    logic wr_cmd;
    logic cas_cmd;

    assign ck_edge = s2_q[3] && s3_q[3] && !flt_q[3];
    assign wr_cmd  = ck_edge && (flt_q[2] || flt_q[1]); // R7
    assign cas_cmd = ck_edge && flt_q[0];

    // ------------------------------------------------------------------
    // Latency table
    // ------------------------------------------------------------------
    logic        data_en;
    logic        low_power;
    logic        burst_length_32;
    logic        lat_ok;
    logic [5:0]  on_lat;
    logic [5:0]  off_lat;
    logic [5:0]  tab_off;

    assign data_en   = cfg_q[`DATA_EN_BIT] &&
                       (cfg_q[`DATA_DIV_MSB:`DATA_DIV_LSB] != 3'h0); // R5 R6
    assign low_power = PWR_DOWN || SELF_REFRESH;
    assign burst_length_32      = ctrl_q[`CTRL_BURST_LENGTH_32_BIT];

    always_comb begin
        lat_ok  = 1'b1;
        on_lat  = 6'h00;
        tab_off = 6'h00;
        case ({ctrl_q[`CTRL_BIN_MSB:`CTRL_BIN_LSB], ctrl_q[`CTRL_SET_B_BIT]}) // R13 R14
            4'h5:    begin on_lat = 6'd6;  tab_off = 6'd22; end
            4'h6:    begin on_lat = 6'd4;  tab_off = 6'd20; end
            4'h7:    begin on_lat = 6'd12; tab_off = 6'd28; end
            4'h8:    begin on_lat = 6'd4;  tab_off = 6'd22; end
            4'h9:    begin on_lat = 6'd14; tab_off = 6'd32; end
            4'hA:    begin on_lat = 6'd6;  tab_off = 6'd24; end
            4'hB:    begin on_lat = 6'd18; tab_off = 6'd36; end
            4'hC:    begin on_lat = 6'd6;  tab_off = 6'd26; end
            4'hD:    begin on_lat = 6'd20; tab_off = 6'd40; end
            4'hE:    begin on_lat = 6'd8;  tab_off = 6'd28; end
            4'hF:    begin on_lat = 6'd24; tab_off = 6'd44; end
            default: lat_ok = 1'b0;
        endcase
    end

    assign off_lat = burst_length_32 ? tab_off + 6'(`BURST_LENGTH_32_EXTRA_CK) : tab_off; // R16

    // ------------------------------------------------------------------
    // Command tracking and latency count
    // ------------------------------------------------------------------
    // Only a column command that follows a write or mask write starts a
    // termination window; reads and other column commands leave it alone.
    logic        armed_q;
    logic        cas_fire;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_nx;
    logic        on_hit;
    logic        off_hit;

    assign cas_fire = cas_cmd && armed_q;
    assign cnt_nx   = cnt_q + 6'h01;
    assign on_hit   = ck_edge && !cas_fire && (cnt_nx == on_lat);   // R9
    assign off_hit  = ck_edge && !cas_fire && (cnt_nx == off_lat);  // R10

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            armed_q <= 1'b0;
        end else if (wr_cmd) begin
            armed_q <= 1'b1;
        end else if (cas_cmd) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cnt_q <= 6'h00;
        end else if (cas_fire) begin
            cnt_q <= 6'h00;
        end else if (ck_edge && cnt_q != 6'h3F) begin
            cnt_q <= cnt_nx;
        end
    end

    // ------------------------------------------------------------------
    // Data termination sequencer
    // ------------------------------------------------------------------
    // Power-down, self refresh, write leveling or a disabled field drop the
    // window at once; the analog ramp is not modelled beyond its least time.
    logic        valid;
    term_state_t state_q;
    term_state_t state_d;
    logic [2:0]  wait_q;
    logic [2:0]  wait_d;

    assign valid = data_en && lat_ok && !low_power && !WRITE_LEVELING; // R3 R4

    always_comb begin
        state_d = state_q;
        wait_d  = (wait_q != 3'h0) ? wait_q - 3'h1 : 3'h0;
        case (state_q)
            T_IDLE: begin
                if (cas_fire) begin
                    state_d = T_ARMED; // R7
                end
            end
            T_ARMED: begin
                if (on_hit) begin
                    state_d = T_RAMP_ON;
                    wait_d  = 3'(TON); // R11
                end
            end
            T_RAMP_ON: begin
                if (wait_q <= 3'h1) begin
                    state_d = T_ON;
                end
            end
            T_ON: begin
                if (off_hit) begin
                    state_d = T_RAMP_OFF; // R8
                    wait_d  = 3'(TOFF); // R12
                end
            end
            T_RAMP_OFF: begin
                if (cas_fire) begin
                    state_d = T_ARMED;
                end else if (wait_q <= 3'h1) begin
                    state_d = T_IDLE; // R8
                end
            end
            default: state_d = T_IDLE;
        endcase
        if (!valid) begin
            state_d = T_IDLE; // R4 R6
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= T_IDLE;
            wait_q  <= 3'h0;
        end else begin
            state_q <= state_d;
            wait_q  <= wait_d;
        end
    end

    // ------------------------------------------------------------------
    // Termination outputs
    // ------------------------------------------------------------------
    logic        dq_d;

    assign dq_d = (state_d == T_ON) || (state_d == T_RAMP_OFF);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            DQ_TERM_EN    <= 1'b0;
            DQS_TERM_EN   <= 1'b0;
            DATA_TERM_DIV <= 3'h0;
        end else begin
            DQ_TERM_EN    <= dq_d && !WRITE_LEVELING; // R17
            DQS_TERM_EN   <= WRITE_LEVELING ? (data_en && !low_power) : dq_d; // R17
            DATA_TERM_DIV <= data_en ? cfg_q[`DATA_DIV_MSB:`DATA_DIV_LSB] : 3'h0; // R5
        end
    end

    // ------------------------------------------------------------------
    // Command-bus termination update
    // ------------------------------------------------------------------
    // The applied value lags the register by the update time so that the
    // receivers never see a half-switched bank of legs.
    logic [7:0]  upd_q;
    logic [2:0]  ca_field;

    assign ca_field = cfg_q[`CA_FIELD_MSB:`CA_FIELD_LSB];

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            upd_q       <= 8'h00;
            CA_TERM_DIV <= 3'h0; // R15
        end else if (ca_write) begin
            upd_q <= 8'(CA_UPD); // R2
        end else if (upd_q != 8'h00) begin
            upd_q <= upd_q - 8'h01;
            if (upd_q == 8'h01) begin
                CA_TERM_DIV <= (ca_field == 3'h7) ? 3'h0 : ca_field; // R1
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RD_STB) begin
            case (ADDR)
                `OFS_TERM_CFG:    RDATA <= cfg_q;
                `OFS_TERM_CTRL:   RDATA <= ctrl_q;
                `OFS_TERM_STATUS: RDATA <= {1'b0, !lat_ok, CA_TERM_DIV,
                                            DQS_TERM_EN, DQ_TERM_EN, armed_q};
                default:          RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    low_power_off_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R4
        low_power |=> (!DQ_TERM_EN && !DQS_TERM_EN))
        else $error("Termination on during power-down or self refresh.");

    disabled_off_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R6
        !cfg_q[`DATA_EN_BIT] |=> !DQ_TERM_EN)
        else $error("Data termination on with top field bit clear.");

    level_dq_off_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R17
        WRITE_LEVELING |=> !DQ_TERM_EN)
        else $error("Data termination on during write leveling.");

    level_dqs_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R17
        (WRITE_LEVELING && !low_power) |=> (DQS_TERM_EN == $past(data_en)))
        else $error("Strobe termination wrong during write leveling.");

    turn_on_time_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R9
        (state_q == T_ARMED && on_hit && valid) |->
            ##[1:TON_P1] (DQ_TERM_EN || !valid))
        else $error("Termination late after turn-on latency.");

    turn_on_early_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R11
        $rose(DQ_TERM_EN) |-> ($past(state_q) == T_RAMP_ON))
        else $error("Termination on without turn-on window.");

    turn_off_time_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R12
        (state_q == T_ON && off_hit && valid && !WRITE_LEVELING) |=>
            DQ_TERM_EN ##[1:TOFF_P1] (!DQ_TERM_EN || cas_fire))
        else $error("Termination off window wrong.");

    off_latency_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R16
        (burst_length_32 && lat_ok) |-> (off_lat == tab_off + 6'(`BURST_LENGTH_32_EXTRA_CK)) && (on_lat < tab_off))
        else $error("Turn-off latency not extended for long burst.");

    ca_update_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R2
        ca_write |-> ##[1:CA_UPD] (upd_q == 8'h01 || ca_write))
        else $error("Command-bus termination not applied in time.");

    ca_decode_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN) // R1
        (upd_q == 8'h01 && !ca_write) |=>
            (CA_TERM_DIV == ((ca_field == 3'h7) ? 3'h0 : ca_field)))
        else $error("Command-bus termination code wrong.");

    term_on_c: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        $rose(DQ_TERM_EN));
    term_off_c: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        $fell(DQ_TERM_EN) && !low_power);
    long_burst_c: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        off_hit && burst_length_32 && state_q == T_ON);
    ca_update_c: cover property (@(posedge CLK_SYS) disable iff (!RSTN)
        upd_q == 8'h01);

endmodule

// *** include/term_consts.svh ***
// Constants of the data and command-bus termination controller.
// Assumes a 250 MHz system clock and the plain register port of the top module.
//
// Contract
// (R1) The command-bus field codes 1..6 select 240, 120, 80, 60, 48 and 40 ohm, i.e. the reference resistor divided by 1..6.
// (R2) A new command-bus value takes effect within the update time after the configuration write, and the controller waits that long.
// (R3) Data, strobe and mask termination are switched by internal logic alone, from write commands and configuration bits.
// (R4) Data termination is off while the die is in power-down or self refresh.
// (R5) Data termination is enabled by a non-zero four-bit data field, whose value selects the resistance; the code also needs the low three bits non-zero.
// (R6) Data termination counts as disabled whenever the top bit of the data field is zero.
// (R7) When enabled, termination rests at high impedance and turns on after a sampled write or mask write command.
// (R8) Termination turns back off to high impedance once the write burst is over.
// (R9) The turn-on latency is a count of command clocks from the second column command, fixed per speed bin.
// (R10) The turn-off latency is a count of command clocks from the second column command, fixed per speed bin.
// (R11) After the turn-on latency, termination leaves high impedance no earlier than the least turn-on time.
// (R12) After the turn-off latency, termination starts turning off no earlier than the least turn-off time.
// (R13) Turn-on latencies for set A/B are n/a/6, 4/12, 4/14, 6/18, 6/20, 8/24 across the six upper speed bins.
// (R14) Turn-off latencies for set A/B are n/a/22, 20/28, 22/32, 24/36, 26/40, 28/44 across the same bins.
// (R15) The command-bus field resets to a value that leaves command-bus termination disabled.
// (R16) A 32-beat burst adds eight command clocks to the turn-off latency.
// (R17) In write leveling, data termination stays off and strobe termination follows the data enable.
`ifndef TERM_CONSTS_SVH
`define TERM_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define OFS_TERM_CFG      8'h0B
`define OFS_TERM_CTRL     8'h10
`define OFS_TERM_STATUS   8'h14
`define TERM_CFG_RESET    8'h00
`define TERM_CTRL_RESET   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DATA_DIV_LSB      0
`define DATA_DIV_MSB      2
`define DATA_EN_BIT       3
`define CA_FIELD_LSB      4
`define CA_FIELD_MSB      6
`define CTRL_BIN_LSB      0
`define CTRL_BIN_MSB      2
`define CTRL_SET_B_BIT    3
`define CTRL_BURST_LENGTH_32_BIT     4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS     4000
`define TERM_ON_MIN_PS    1500
`define TERM_OFF_MIN_PS   1500
`define CA_UPDATE_PS      20000
`define BURST_LENGTH_32_EXTRA_CK     8
`define TERM_ON_MIN_CYC   ((`TERM_ON_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TERM_OFF_MIN_CYC  ((`TERM_OFF_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CA_UPDATE_CYC     ((`CA_UPDATE_PS / `CLK_PERIOD_PS) > 0 ? \
                           (`CA_UPDATE_PS / `CLK_PERIOD_PS) : 1)

`endif

// *** include/term_pkg.sv ***
// Types shared by the termination controller.
// Assumes nothing beyond a SystemVerilog compiler.
package term_pkg;

    // ------------------------------------------------------------------
    // Data termination sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        T_IDLE,
        T_ARMED,
        T_RAMP_ON,
        T_ON,
        T_RAMP_OFF
    } term_state_t;

    typedef logic [2:0] rzq_div_t;

endpackage

// *** verification/cmd_link_model.sv ***
// Partner model: the memory controller playing write frames on the command link.
// Assumes the bench raises start for one frame and waits for busy to fall.
module cmd_link_model (
    input  wire logic       start,
    input  wire logic       mask_sel,
    input  wire logic [7:0] n_edges,
    output logic            cmd_clk,
    output logic            write1,
    output logic            mask_write1,
    output logic            cas2,
    output logic            busy,
    output int              edge_no
);
    timeunit 1ns;
    timeprecision 100ps;
    int i;

    initial begin
        {cmd_clk, write1, mask_write1, cas2, busy} = '0;
        edge_no = -1;
        forever begin
            wait (start);
            busy = 1'b1;
            edge_no = -1;
            // The offset keeps command edges away from system clock edges.
            #1.3;
            // The clock stands still between frames, so no stray edge is ever seen.
            for (i = 0; i < n_edges; i++) begin
                write1 = (i == 0) && !mask_sel;
                mask_write1 = (i == 0) && mask_sel;
                cas2 = (i == 1);
                #32 cmd_clk = 1'b1;
                edge_no = i;
                #32 cmd_clk = 1'b0;
            end
            {write1, mask_write1, cas2} = '0;
            busy = 1'b0;
            wait (!start);
        end
    end
endmodule

// *** verification/dram_termination_control_test.sv ***
// Self-checking bench of the termination controller.
// Assumes the partner model in cmd_link_model.sv and the shared constants header.
`include "term_consts.svh"

module dram_termination_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import term_pkg::*;

    typedef struct {logic dq; logic dqs; int edge_at;} note_t;
    logic       clk_sys = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic       pwr_down = 1'b0, self_ref = 1'b0, wr_lvl = 1'b0, rd_seen = 1'b0;
    logic       start = 1'b0, mask_sel = 1'b0, busy, cmd_clk, write1, mask_write1, cas2;
    logic       dq_en, dqs_en;
    logic [7:0] addr = '0, wdata = '0, rdata, n_edges = '0;
    logic [1:0] prev_en = '0;
    rzq_div_t   data_div, ca_div;
    int         edge_no, error_cnt = 0, total_checks = 0, seed = 25320;
    note_t      term_q[$];
    note_t      n;
    logic [7:0] rd_q[$];
    int         on_lat [2][8] = '{'{0, 0, 0, 4, 4, 6, 6, 8}, '{0, 0, 6, 12, 14, 18, 20, 24}};
    int         off_lat [2][8] = '{'{0, 0, 0, 20, 22, 24, 26, 28}, '{0, 0, 22, 28, 32, 36, 40, 44}};

    always #2 clk_sys = ~clk_sys;

    dram_termination_control u_dut (
        .CLK_SYS(clk_sys), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .CMD_CLOCK_TRUE(cmd_clk),
        .CMD_WRITE1(write1), .CMD_MASK_WRITE1(mask_write1), .CMD_CAS2(cas2),
        .PWR_DOWN(pwr_down), .SELF_REFRESH(self_ref), .WRITE_LEVELING(wr_lvl),
        .DQ_TERM_EN(dq_en), .DQS_TERM_EN(dqs_en), .DATA_TERM_DIV(data_div), .CA_TERM_DIV(ca_div)
    );

    cmd_link_model u_link (
        .start(start), .mask_sel(mask_sel), .n_edges(n_edges), .cmd_clk(cmd_clk),
        .write1(write1), .mask_write1(mask_write1), .cas2(cas2), .busy(busy), .edge_no(edge_no)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        check(16'(term_q.size()), 16'h0000);
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk_sys);
        rd_stb <= 1'b0;
    endtask

    task automatic note(input logic a, input logic b, input int e);
        term_q.push_back('{a, b, e});
    endtask

    task automatic frame(input logic m, input int e);
        @(posedge clk_sys);
        mask_sel <= m;
        n_edges <= 8'(e);
        start <= 1'b1;
        repeat (2) @(posedge clk_sys);
        start <= 1'b0;
        while (busy) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_en = 2'b00;
        end else begin
            if (rd_seen) check(16'(rdata), 16'(rd_q.pop_front()));
            if ({dq_en, dqs_en} !== prev_en) begin
                if (term_q.size() == 0) begin
                    check(16'({dq_en, dqs_en}), 16'(prev_en));
                end else begin
                    n = term_q.pop_front();
                    check(16'({dq_en, dqs_en}), 16'({n.dq, n.dqs}));
                    if (n.edge_at >= 0) check(16'(edge_no), 16'(n.edge_at));
                end
                prev_en = {dq_en, dqs_en};
            end
        end
        rd_seen = rd_stb;
    end

    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int b, s, d, c, ca_e, lat_off;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`OFS_TERM_CFG, `TERM_CFG_RESET);
        rd(`OFS_TERM_CTRL, `TERM_CTRL_RESET);
        rd(`OFS_TERM_STATUS, 8'h40);
        check(16'(ca_div), 16'h0000);
        wr(8'h20, 8'h5A);
        rd(8'h20, 8'h00);
        for (c = 0; c < 8; c++) begin
            ca_e = (c > 0 && c < 7) ? c : 0;
            wr(`OFS_TERM_CFG, {1'b1, 3'(c), 4'hB});
            // No done flag exists, so the wait is the update time plus two cycles.
            repeat (`CA_UPDATE_CYC + 2) @(posedge clk_sys);
            check(16'(ca_div), 16'(ca_e));
            check(16'(data_div), 16'h0003);
            rd(`OFS_TERM_CFG, {1'b0, 3'(c), 4'hB});
            rd(`OFS_TERM_STATUS, {2'b01, 3'(ca_e), 3'b000});
        end
        for (d = 0; d < 16; d++) begin
            wr(`OFS_TERM_CFG, 8'(d));
            repeat (2) @(posedge clk_sys);
            check(16'(data_div), (d[3] && d[2:0] != 0) ? 16'(d[2:0]) : 16'h0000);
        end
        wr(`OFS_TERM_CTRL, 8'hFF);
        rd(`OFS_TERM_CTRL, 8'h1F);
        for (b = 2; b < 8; b++) begin
            for (s = 0; s < 2; s++) begin
                d = ($random(seed) & 7) % 7 + 1;
                lat_off = off_lat[s][b] + ((b[0] ^ s[0]) ? `BURST_LENGTH_32_EXTRA_CK : 0);
                wr(`OFS_TERM_CTRL, {3'b000, b[0] ^ s[0], s[0], 3'(b)});
                wr(`OFS_TERM_CFG, {1'b0, 3'($random(seed)), 1'b1, 3'(d)});
                if (on_lat[s][b] > 0) begin
                    note(1'b1, 1'b1, 1 + on_lat[s][b]);
                    note(1'b0, 1'b0, 1 + lat_off);
                end
                frame(b[0], 58);
                check(16'(data_div), 16'(d));
            end
        end
        wr(`OFS_TERM_CTRL, 8'h07);
        wr(`OFS_TERM_CFG, 8'h0B);
        note(1'b1, 1'b1, 9);
        note(1'b0, 1'b0, -1);
        fork
            frame(1'b0, 33);
            begin
                wait (dq_en === 1'b1);
                rd(`OFS_TERM_STATUS, 8'h06);
                pwr_down <= 1'b1;
                repeat (2) @(posedge clk_sys);
                check(16'(dq_en), 16'h0000);
            end
        join
        pwr_down <= 1'b0;
        self_ref <= 1'b1;
        frame(1'b1, 33);
        self_ref <= 1'b0;
        note(1'b0, 1'b1, -1);
        note(1'b0, 1'b0, -1);
        wr_lvl <= 1'b1;
        frame(1'b0, 33);
        wr_lvl <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr(`OFS_TERM_CFG, 8'h03);
        wr_lvl <= 1'b1;
        frame(1'b1, 33);
        wr_lvl <= 1'b0;
        wr(`OFS_TERM_CFG, 8'h08);
        frame(1'b0, 33);
        print_verdict();
    end
endmodule
